/* File: hdl/pde_pkg.sv */
package pde_pkg;

	// ----------------------------------------------------------------
	// Register map on the classic Wishbone slave
	// ----------------------------------------------------------------
	localparam int WB_AW = 4; // Byte address width of the slave
	localparam logic [3:0] WB_MODE_STATUS = 4'h0; // Read-only mode view
	localparam logic [3:0] WB_PSEL_IO = 4'h4; // Program-select pin as I/O

	// Fields of the mode status register
	localparam int ST_MODE_LSB = 0; // Two bits of current mode
	localparam int ST_LVEN_BIT = 2; // Low-voltage programming enable
	localparam int ST_DBG_BIT = 3; // Debugger function enabled
	localparam int ST_CPOFF_BIT = 4; // Code protection unprogrammed
	localparam int ST_PSEL_BIT = 5; // Synchronised program-select level
	localparam int ST_CORE_BIT = 6; // Core is executing

	// Fields of the program-select I/O register
	localparam int IO_OUT_BIT = 0; // Level driven when used as output
	localparam int IO_OE_BIT = 1; // Drive enable when used as output
	localparam int IO_PIN_BIT = 2; // Read-only pin level
	localparam int IO_PULL_BIT = 3; // Weak pull-up request
	localparam logic [3:0] IO_RESET = 4'h0; // Input, no pull-up

	// ----------------------------------------------------------------
	// Configuration word and memory map seen from the serial link
	// ----------------------------------------------------------------
	localparam int CFG_W = 14; // Width of every stored word
	localparam logic [13:0] CFG_RESET = 14'h3FFF; // Erased, as delivered
	localparam int CFG_LVEN_BIT = 7; // 1 = low-voltage entry enabled
	localparam int CFG_DBG_BIT = 11; // 0 = debugger enabled
	localparam int CFG_CP_BIT = 13; // 1 = code protection off
	localparam logic [13:0] ID_BASE = 14'h2000; // First ID word
	localparam logic [13:0] ID_LAST = 14'h2003; // Last ID word
	localparam logic [13:0] CFG_ADDR = 14'h2007; // Configuration word

	// Resources that the debugger keeps for itself
	localparam logic [13:0] DBG_NOP_ADDR = 14'h0000; // Must hold a no-op
	localparam logic [13:0] DBG_PROG_WORDS = 14'h0100; // Top of memory
	localparam logic [8:0] DBG_DATA_MAIN = 9'h070; // And its mirrors
	localparam logic [8:0] DBG_DATA_LO = 9'h1EB; // Reserved data block
	localparam logic [8:0] DBG_DATA_HI = 9'h1EF;

	// ----------------------------------------------------------------
	// Serial link framing
	// ----------------------------------------------------------------
	localparam int CMD_W = 6; // Command bits, LSB first
	localparam int PAY_W = 16; // Payload bits, LSB first
	localparam logic [5:0] CMD_LOAD_ADDR = 6'h01; // Payload sets address
	localparam logic [5:0] CMD_LOAD_DATA = 6'h02; // Payload is stored
	localparam logic [5:0] CMD_READ_DATA = 6'h04; // Device returns word
	localparam logic [5:0] CMD_INC_ADDR = 6'h06; // Address plus one
	localparam logic [4:0] CMD_LAST = 5'h05; // Count at last command bit
	localparam logic [4:0] PAY_LAST = 5'h0F; // Count at last payload bit

	// Modes of the entry controller
	typedef enum logic [1:0] {
		PDE_RUN,
		PDE_HV_PROG,
		PDE_LV_PROG
	} pde_mode_t;

	// Phases of one serial frame
	typedef enum logic [1:0] {
		PDE_LK_CMD,
		PDE_LK_LOAD,
		PDE_LK_READ
	} pde_link_t;

endpackage

/* File: hdl/pde_link.sv */
`timescale 1ns/1ns
`default_nettype none

// Serial programming link, clocked by the programmer's clock
module pde_link #(
	parameter int PROG_DEPTH = 1024
) (
	input wire logic serial_program_clock,
	input wire logic sys_rst,
	input wire logic prog_active,
	input wire logic hv_active,
	input wire logic serial_program_data_in,
	output logic serial_program_data_out_q,
	output logic serial_program_data_oe_q,
	output logic [13:0] cfg_word_q
);

	// ----------------------------------------------------------------
	// Crossings into the link domain
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_q; // Reset level, two stages
	logic [1:0] prog_sync_q; // Programming mode level
	logic [1:0] hv_sync_q; // High-voltage entry level
	logic link_rst; // Resets the configuration word and the framer
	logic frame_rst; // Idles the framer outside programming

	// Levels only; the first stage feeds nothing but the second
	always_ff @(posedge serial_program_clock) begin
		rst_sync_q <= {rst_sync_q[0], sys_rst};
		prog_sync_q <= {prog_sync_q[0], prog_active};
		hv_sync_q <= {hv_sync_q[0], hv_active};
	end

	assign link_rst = rst_sync_q[1];
	assign frame_rst = link_rst | ~prog_sync_q[1];

	// ----------------------------------------------------------------
	// Framer
	// ----------------------------------------------------------------
	pde_pkg::pde_link_t phase_q; // Phase of the current frame
	logic [5:0] cmd_q; // Command shifted in
	logic [5:0] cmd_next; // Command including this edge's bit
	logic [4:0] cnt_q; // Bit counter within a phase
	logic [15:0] shift_q; // Payload in or out
	logic [15:0] pay_next; // Payload including this edge's bit
	logic [13:0] addr_q; // Current word address
	logic [13:0] rd_word; // Word at the current address
	logic wr_en; // Store the finished payload
	logic [13:0] prog_mem [PROG_DEPTH]; // Program words
	logic [13:0] id_mem [4]; // ID words
	localparam logic [13:0] PROG_LIMIT = 14'(PROG_DEPTH);
	localparam int PAW = $clog2(PROG_DEPTH);

	assign cmd_next = {serial_program_data_in, cmd_q[5:1]};
	assign pay_next = {serial_program_data_in, shift_q[15:1]};
	assign wr_en = (phase_q == pde_pkg::PDE_LK_LOAD) &&
		(cnt_q == pde_pkg::PAY_LAST) && (cmd_q == pde_pkg::CMD_LOAD_DATA);

	// Clock and one data line carry every command
	always_ff @(posedge serial_program_clock) begin
		if (frame_rst) begin
			phase_q <= pde_pkg::PDE_LK_CMD;
			cmd_q <= '0;
			cnt_q <= '0;
			shift_q <= '0;
			addr_q <= '0;
			serial_program_data_out_q <= 1'b0;
			serial_program_data_oe_q <= 1'b0;
		end else begin
			case (phase_q)
			pde_pkg::PDE_LK_CMD: begin
				cmd_q <= cmd_next;
				cnt_q <= cnt_q + 5'h01;
				if (cnt_q == pde_pkg::CMD_LAST) begin
					cnt_q <= '0;
					if (cmd_next == pde_pkg::CMD_LOAD_ADDR ||
						cmd_next == pde_pkg::CMD_LOAD_DATA) begin
						phase_q <= pde_pkg::PDE_LK_LOAD;
					end else if (cmd_next == pde_pkg::CMD_READ_DATA) begin
						// Device takes the line for sixteen clocks
						phase_q <= pde_pkg::PDE_LK_READ;
						shift_q <= {2'b00, rd_word};
						serial_program_data_out_q <= rd_word[0];
						serial_program_data_oe_q <= 1'b1;
					end else if (cmd_next == pde_pkg::CMD_INC_ADDR) begin
						addr_q <= addr_q + 14'h0001;
					end
				end
			end
			pde_pkg::PDE_LK_LOAD: begin
				shift_q <= pay_next;
				cnt_q <= cnt_q + 5'h01;
				if (cnt_q == pde_pkg::PAY_LAST) begin
					cnt_q <= '0;
					phase_q <= pde_pkg::PDE_LK_CMD;
					if (cmd_q == pde_pkg::CMD_LOAD_ADDR) begin
						addr_q <= pay_next[13:0];
					end
				end
			end
			pde_pkg::PDE_LK_READ: begin
				shift_q <= {1'b0, shift_q[15:1]};
				serial_program_data_out_q <= shift_q[1];
				cnt_q <= cnt_q + 5'h01;
				if (cnt_q == pde_pkg::PAY_LAST) begin
					cnt_q <= '0;
					phase_q <= pde_pkg::PDE_LK_CMD;
					serial_program_data_oe_q <= 1'b0;
				end
			end
			default: begin
				phase_q <= pde_pkg::PDE_LK_CMD;
			end
			endcase
		end
	end

	// Memory words are nonvolatile in intent, so they have no reset
	always_ff @(posedge serial_program_clock) begin
		if (wr_en && addr_q < PROG_LIMIT) begin
			prog_mem[addr_q[PAW-1:0]] <= pay_next[13:0];
		end
		if (wr_en && addr_q >= pde_pkg::ID_BASE &&
			addr_q <= pde_pkg::ID_LAST) begin
			id_mem[addr_q[1:0]] <= pay_next[13:0];
		end
	end

	// Reset models the delivered, erased word; a limitation of the model
	always_ff @(posedge serial_program_clock) begin
		if (link_rst) begin
			cfg_word_q <= pde_pkg::CFG_RESET;
		end else if (wr_en && addr_q == pde_pkg::CFG_ADDR) begin
			cfg_word_q <= pay_next[13:0];
			// Enable bit only moves under high-voltage entry
			if (!hv_sync_q[1]) begin
				cfg_word_q[pde_pkg::CFG_LVEN_BIT] <=
					cfg_word_q[pde_pkg::CFG_LVEN_BIT];
			end
		end
	end

	// Read source; program words hidden once protection is set
	always_comb begin
		rd_word = '0;
		if (addr_q < PROG_LIMIT) begin
			if (cfg_word_q[pde_pkg::CFG_CP_BIT]) begin
				rd_word = prog_mem[addr_q[PAW-1:0]];
			end
		end else if (addr_q >= pde_pkg::ID_BASE &&
			addr_q <= pde_pkg::ID_LAST) begin
			rd_word = id_mem[addr_q[1:0]];
		end else if (addr_q == pde_pkg::CFG_ADDR) begin
			rd_word = cfg_word_q;
		end
	end

	// ----------------------------------------------------------------
	// Checks on the link side
	// ----------------------------------------------------------------
	lven_guard_a: assert property (@(posedge serial_program_clock)
		disable iff (link_rst)
		(wr_en && addr_q == pde_pkg::CFG_ADDR && !hv_sync_q[1]) |=>
		$stable(cfg_word_q[pde_pkg::CFG_LVEN_BIT]))
		else $error("enable bit changed without high voltage");

	link_idle_a: assert property (@(posedge serial_program_clock)
		disable iff (link_rst)
		!prog_sync_q[1] |=> !serial_program_data_oe_q)
		else $error("data line driven outside programming");

	link_read_c: cover property (@(posedge serial_program_clock)
		disable iff (link_rst)
		phase_q == pde_pkg::PDE_LK_READ ##16
		phase_q == pde_pkg::PDE_LK_CMD);

endmodule

`default_nettype wire

/* File: hdl/pde_entry.sv */
// The implementer's own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module pde_entry #(
	parameter int PROG_DEPTH = 1024
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [pde_pkg::WB_AW-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic master_clear_pin,
	input wire logic high_program_voltage_level,
	input wire logic program_select_pin_in,
	output logic program_select_pin_out_q,
	output logic program_select_pin_oe_q,
	output logic program_select_pull_up_q,
	input wire logic serial_program_clock,
	input wire logic serial_program_data_in,
	output logic serial_program_data_out_q,
	output logic serial_program_data_oe_q,
	output logic core_run_q,
	output logic prog_mode_q,
	output logic hv_mode_q,
	output logic debug_enable_q,
	output logic debug_reserved_q
);

	// ----------------------------------------------------------------
	// Pin and configuration synchronisers
	// ----------------------------------------------------------------
	logic [1:0] clr_sync_q; // Clear pin, [1] is usable
	logic [1:0] hv_sync_q; // High-voltage detector
	logic [1:0] psel_sync_q; // Program-select pin
	logic clr_prev_q; // Clear level one cycle back
	logic [2:0] cfg_meta_q; // First stage, read only by the second
	logic [2:0] cfg_sync_q; // {protect off, debug bit, enable}
	logic [13:0] cfg_word; // Configuration word in the link domain
	logic clr_s; // Clear pin released (high)
	logic hv_s; // High programming voltage present
	logic psel_s; // Program-select pin high
	logic clr_rise; // Clear pin just released
	logic lven_s; // Low-voltage entry enabled
	logic dbg_bit_s; // Debugger bit, zero means on
	logic cpoff_s; // Protection bits unprogrammed

	// Every outside level passes two flops before use
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			clr_sync_q <= 2'h0;
			hv_sync_q <= 2'h0;
			psel_sync_q <= 2'h0;
			clr_prev_q <= 1'b0;
		end else begin
			clr_sync_q <= {clr_sync_q[0], master_clear_pin};
			hv_sync_q <= {hv_sync_q[0], high_program_voltage_level};
			psel_sync_q <= {psel_sync_q[0], program_select_pin_in};
			clr_prev_q <= clr_sync_q[1];
		end
	end

	// Configuration bits are quasi-static, each crossed on its own
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg_meta_q <= 3'h7; // Delivered state
			cfg_sync_q <= 3'h7;
		end else begin
			cfg_meta_q <= {cfg_word[pde_pkg::CFG_CP_BIT],
				cfg_word[pde_pkg::CFG_DBG_BIT],
				cfg_word[pde_pkg::CFG_LVEN_BIT]};
			cfg_sync_q <= cfg_meta_q;
		end
	end

	assign clr_s = clr_sync_q[1];
	assign hv_s = hv_sync_q[1];
	assign psel_s = psel_sync_q[1];
	assign clr_rise = clr_s & ~clr_prev_q;
	assign lven_s = cfg_sync_q[0];
	assign dbg_bit_s = cfg_sync_q[1];
	assign cpoff_s = cfg_sync_q[2];

	// ----------------------------------------------------------------
	// Entry state machine
	// ----------------------------------------------------------------
	pde_pkg::pde_mode_t mode_q; // Current mode
	pde_pkg::pde_mode_t mode_d; // Next mode

	always_comb begin
		mode_d = mode_q;
		case (mode_q)
		pde_pkg::PDE_RUN: begin
			if (hv_s) begin
				mode_d = pde_pkg::PDE_HV_PROG;
			end else if (clr_rise && lven_s && psel_s) begin
				// Select is looked at only on release of clear
				mode_d = pde_pkg::PDE_LV_PROG;
			end
		end
		pde_pkg::PDE_HV_PROG: begin
			if (!hv_s && !clr_s) begin
				mode_d = pde_pkg::PDE_RUN;
			end
		end
		pde_pkg::PDE_LV_PROG: begin
			if (hv_s) begin
				mode_d = pde_pkg::PDE_HV_PROG;
			end else if (!clr_s) begin
				mode_d = pde_pkg::PDE_RUN;
			end
		end
		default: begin
			mode_d = pde_pkg::PDE_RUN;
		end
		endcase
	end

	// Low-voltage entry needs the enable, so a cleared bit blocks it
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mode_q <= pde_pkg::PDE_RUN;
		end else begin
			mode_q <= mode_d;
		end
	end

	// Mode outputs follow the next state so they align with mode_q
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			core_run_q <= 1'b0;
			prog_mode_q <= 1'b0;
			hv_mode_q <= 1'b0;
		end else begin
			// Core held while programming or clear is low
			core_run_q <= (mode_d == pde_pkg::PDE_RUN) && clr_s;
			prog_mode_q <= mode_d != pde_pkg::PDE_RUN;
			hv_mode_q <= mode_d == pde_pkg::PDE_HV_PROG;
		end
	end

	// Debugger reservation follows the inverted configuration bit
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			debug_enable_q <= 1'b0;
			debug_reserved_q <= 1'b0;
		end else begin
			debug_enable_q <= !dbg_bit_s;
			debug_reserved_q <= !dbg_bit_s;
		end
	end

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	logic [3:0] psel_io_q; // Program-select I/O control
	logic wb_hit; // Request waiting for its answer
	logic [31:0] rd_d; // Read data for the addressed word

	assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;

	// One wait cycle, then ack for exactly one cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_hit;
		end
	end

	// Writes land at the acking edge; ignored while in programming mode
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			psel_io_q <= pde_pkg::IO_RESET;
		end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
			wb_sel_i[0] && !prog_mode_q &&
			wb_adr_i == pde_pkg::WB_PSEL_IO) begin
			psel_io_q <= wb_dat_i[3:0];
		end
	end

	// Unmapped words read as zero and are still acknowledged
	always_comb begin
		rd_d = '0;
		case (wb_adr_i)
		pde_pkg::WB_MODE_STATUS: begin
			rd_d[pde_pkg::ST_MODE_LSB +: 2] = mode_q;
			rd_d[pde_pkg::ST_LVEN_BIT] = lven_s;
			rd_d[pde_pkg::ST_DBG_BIT] = debug_enable_q;
			rd_d[pde_pkg::ST_CPOFF_BIT] = cpoff_s;
			rd_d[pde_pkg::ST_PSEL_BIT] = psel_s;
			rd_d[pde_pkg::ST_CORE_BIT] = core_run_q;
		end
		pde_pkg::WB_PSEL_IO: begin
			rd_d[3:0] = psel_io_q;
			rd_d[pde_pkg::IO_PIN_BIT] = psel_s;
		end
		default: begin
			rd_d = '0;
		end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wb_dat_o <= '0;
		end else if (wb_hit) begin
			wb_dat_o <= rd_d;
		end else begin
			wb_dat_o <= '0;
		end
	end

	// ----------------------------------------------------------------
	// Program-select pin ownership
	// ----------------------------------------------------------------
	// Dedicated to entry while enabled, plain I/O when cleared
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			program_select_pin_out_q <= 1'b0;
			program_select_pin_oe_q <= 1'b0;
			program_select_pull_up_q <= 1'b0;
		end else if (lven_s) begin
			program_select_pin_out_q <= 1'b0;
			program_select_pin_oe_q <= 1'b0;
			// Pull-up would hold select high; off unless the pull-up and drive-enable bits are both set
			program_select_pull_up_q <= psel_io_q[pde_pkg::IO_PULL_BIT]
				&& psel_io_q[pde_pkg::IO_OE_BIT];
		end else begin
			program_select_pin_out_q <= psel_io_q[pde_pkg::IO_OUT_BIT];
			program_select_pin_oe_q <= psel_io_q[pde_pkg::IO_OE_BIT];
			program_select_pull_up_q <= psel_io_q[pde_pkg::IO_PULL_BIT]
				&& !psel_io_q[pde_pkg::IO_OE_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Serial link in its own clock domain
	// ----------------------------------------------------------------
	pde_link #(
		.PROG_DEPTH(PROG_DEPTH)
	) u_link (
		.serial_program_clock(serial_program_clock),
		.sys_rst(sys_rst),
		.prog_active(prog_mode_q),
		.hv_active(hv_mode_q),
		.serial_program_data_in(serial_program_data_in),
		.serial_program_data_out_q(serial_program_data_out_q),
		.serial_program_data_oe_q(serial_program_data_oe_q),
		.cfg_word_q(cfg_word)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	hv_entry_a: assert property (hv_s |=> hv_mode_q)
		else $error("high voltage did not force programming");

	lv_entry_a: assert property (
		(mode_q == pde_pkg::PDE_RUN && !hv_s && clr_rise && lven_s &&
		psel_s) |=> (mode_q == pde_pkg::PDE_LV_PROG) && prog_mode_q)
		else $error("low-voltage entry missed");

	lv_block_a: assert property (
		(mode_q == pde_pkg::PDE_RUN && !lven_s) |=>
		mode_q != pde_pkg::PDE_LV_PROG)
		else $error("low-voltage entry with enable cleared");

	pin_dedic_a: assert property (
		lven_s |=> !program_select_pin_oe_q ##0 !program_select_pin_out_q)
		else $error("select pin driven while dedicated");

	pin_gpio_a: assert property (
		(!lven_s && psel_io_q[pde_pkg::IO_OE_BIT]) |=>
		program_select_pin_oe_q)
		else $error("select pin not released as I/O");

	core_hold_a: assert property (
		mode_q != pde_pkg::PDE_RUN |-> !core_run_q && prog_mode_q)
		else $error("core running during programming");

	dbg_enable_a: assert property (
		!dbg_bit_s |=> debug_enable_q ##0 debug_reserved_q)
		else $error("debugger not enabled by zero bit");

	wb_answer_a: assert property (
		wb_hit |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer not one cycle after request");

	mode_exit_a: assert property (
		(mode_q == pde_pkg::PDE_LV_PROG && !clr_s && !hv_s) |=>
		mode_q == pde_pkg::PDE_RUN && !core_run_q)
		else $error("low-voltage mode not left on clear");

	hv_mode_c: cover property (mode_q == pde_pkg::PDE_HV_PROG);
	lv_mode_c: cover property (mode_q == pde_pkg::PDE_LV_PROG);
	io_write_c: cover property (wb_ack_o && wb_we_i &&
		wb_adr_i == pde_pkg::WB_PSEL_IO);

endmodule

`default_nettype wire

/* File: verification/pde_prog_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------
// Programmer model on the far side of the link
// ------------------------------------------------
module pde_prog_model (
	input wire logic rst_run,
	output logic serial_program_clock,
	output logic serial_program_data_in,
	input wire logic serial_program_data_out_q,
	input wire logic serial_program_data_oe_q
);
	logic drv_q; // Model drives data
	logic val_q; // Level it drives
	logic last_q; // Last level seen
	// One clock and one data line; released line flips
	assign serial_program_data_in = serial_program_data_oe_q ?
		serial_program_data_out_q : (drv_q ? val_q : ~last_q);
	initial begin
		serial_program_clock = 1'b0;
		drv_q = 1'b0;
		val_q = 1'b0;
		last_q = 1'b0;
	end
	// Clock runs in reset only, so the link domain resets; else still
	always begin
		#3;
		if (rst_run) begin
			serial_program_clock = ~serial_program_clock;
		end
	end
	// One link clock; data changes while the clock is low
	task automatic tick(input logic dr, input logic d, output logic q);
		serial_program_clock = 1'b0;
		drv_q = dr;
		val_q = d;
		#3 serial_program_clock = 1'b1;
		#3 q = serial_program_data_in;
		last_q = q;
		serial_program_clock = 1'b0;
	endtask
	// Two lead-in clocks so the link sees programming mode
	task automatic wake();
		logic q;
		tick(1'b1, 1'b0, q);
		tick(1'b1, 1'b0, q);
	endtask
	// Six command bits then sixteen payload clocks, LSB first
	task automatic frame(input logic [5:0] c, input logic [15:0] p,
		output logic [15:0] r);
		logic q;
		r = '0;
		for (int i = 0; i < 6; i++) tick(1'b1, c[i], q);
		r[0] = q;
		// Device drives read data; model lets go of the line
		for (int i = 0; i < 16; i++) begin
			tick(c != pde_pkg::CMD_READ_DATA, p[i], q);
			if (i < 15) r[i+1] = q;
		end
		drv_q = 1'b0;
	endtask
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ns
`default_nettype none

module testbench;
	logic clk, sys_rst, cyc, stb, we, clr_pin, hv, sel_drv, ack;
	logic [3:0] adr;
	logic [31:0] dat, rdat;
	logic sel_out, sel_oe, sel_pu, lk_clk, lk_in, lk_out, lk_oe;
	logic core, prog, hvm, dbg, dres;
	int bad_count = 0;
	int checks_done = 0;
	always #20 clk = ~clk;
	pde_entry #(.PROG_DEPTH(16)) u_dut (.clk(clk), .sys_rst(sys_rst),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.master_clear_pin(clr_pin), .high_program_voltage_level(hv),
		.program_select_pin_in(sel_oe ? sel_out : sel_drv),
		.program_select_pin_out_q(sel_out),
		.program_select_pin_oe_q(sel_oe),
		.program_select_pull_up_q(sel_pu),
		.serial_program_clock(lk_clk), .serial_program_data_in(lk_in),
		.serial_program_data_out_q(lk_out),
		.serial_program_data_oe_q(lk_oe), .core_run_q(core),
		.prog_mode_q(prog), .hv_mode_q(hvm), .debug_enable_q(dbg),
		.debug_reserved_q(dres));
	pde_prog_model u_prog (.rst_run(sys_rst),
		.serial_program_clock(lk_clk), .serial_program_data_in(lk_in),
		.serial_program_data_out_q(lk_out),
		.serial_program_data_oe_q(lk_oe));
	// ------------------------------------------------
	// Reporting
	// ------------------------------------------------
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// ------------------------------------------------
	// Bus and link access
	// ------------------------------------------------
	// Classic cycle; holds until ack is sampled high
	task automatic wb(input logic w, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		// Start right after a rising edge; ack is judged at rising edges
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		@(posedge clk);
		while (ack !== 1'b1 && n < 20) begin
			n++;
			@(posedge clk);
		end
		if (n == 20) begin
			bad_count++;
			finish_test();
		end
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input string n, input logic [3:0] a,
		input logic [31:0] e);
		logic [31:0] r;
		wb(1'b0, a, '0, r);
		chk(n, e, r);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] r;
		wb(1'b1, a, d, r);
		repeat (3) @(posedge clk);
	endtask
	task automatic lw(input logic [15:0] a, input logic [15:0] d);
		logic [15:0] r;
		u_prog.frame(pde_pkg::CMD_LOAD_ADDR, a, r);
		u_prog.frame(pde_pkg::CMD_LOAD_DATA, d, r);
	endtask
	task automatic lr(input string n, input logic [15:0] a,
		input logic [15:0] e);
		logic [15:0] r;
		u_prog.frame(pde_pkg::CMD_LOAD_ADDR, a, r);
		u_prog.frame(pde_pkg::CMD_READ_DATA, 16'h0000, r);
		chk(n, 32'(e), 32'(r));
	endtask
	// Pin changes settle through two syncs, state and output
	task automatic settle();
		repeat (8) @(posedge clk);
	endtask
	// Supply up, clear low, select high, clear high
	task automatic lv_entry();
		clr_pin <= 1'b0;
		settle();
		sel_drv <= 1'b1;
		settle();
		clr_pin <= 1'b1;
		settle();
	endtask
	task automatic leave();
		clr_pin <= 1'b0;
		hv <= 1'b0;
		sel_drv <= 1'b0;
		settle();
		// Idle link clocks let the framer see programming has ended
		u_prog.wake();
		@(posedge clk);
		clr_pin <= 1'b1;
		settle();
	endtask
	// ------------------------------------------------
	// Hang guard and main sequence
	// ------------------------------------------------
	initial begin
		repeat (60000) @(posedge clk);
		bad_count++;
		finish_test();
	end
	initial begin
		{clk, cyc, stb, we, hv, sel_drv} = '0;
		{adr, dat} = '0;
		{sys_rst, clr_pin} = 2'b11;
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		settle();
		chk("core", 1, core);
		rd("status", pde_pkg::WB_MODE_STATUS, 32'h54);
		chk("dbg", 0, dbg);
		wr(pde_pkg::WB_PSEL_IO, 32'h3);
		chk("sel_oe", 0, sel_oe);
		$display("test delivered done");
		lv_entry();
		u_prog.wake();
		chk("prog", 1, prog);
		chk("hv", 0, hvm);
		chk("core", 0, core);
		wr(pde_pkg::WB_PSEL_IO, 32'h0);
		rd("io", pde_pkg::WB_PSEL_IO, 32'h7);
		lw(16'h2000, 16'h0005);
		lr("id", 16'h2000, 16'h0005);
		lw(16'h0003, 16'hEA5A);
		lr("word", 16'h0003, 16'h2A5A);
		lw(16'h2007, 16'h3F7F);
		lr("cfg_lv", 16'h2007, 16'h3FFF);
		leave();
		$display("test low voltage done");
		hv <= 1'b1;
		settle();
		u_prog.wake();
		chk("hv", 1, hvm);
		lw(16'h2007, 16'h377F);
		lr("cfg_hv", 16'h2007, 16'h377F);
		leave();
		chk("dbg", 1, dbg);
		chk("dres", 1, dres);
		$display("test high voltage done");
		wr(pde_pkg::WB_PSEL_IO, 32'hB);
		chk("sel", 2'b11, {sel_oe, sel_out});
		chk("pull", 0, sel_pu);
		wr(pde_pkg::WB_PSEL_IO, 32'h8);
		chk("pull", 1, sel_pu);
		lv_entry();
		chk("prog", 0, prog);
		hv <= 1'b1;
		settle();
		chk("hv", 1, hvm);
		leave();
		rd("unmapped", 4'h8, 32'h0);
		$display("test disabled done");
		finish_test();
	end
endmodule
`default_nettype wire
